// ---- common/pwc_pkg.sv ----
// Constants and types shared by the PWM group with capture
package pwc_pkg;
  localparam int NCH   = 8;
  localparam int NPAIR = 4;
  localparam int NGEN  = 4;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_PRESCALE   = 8'h00;
  localparam logic [7:0] OFS_CLKSEL     = 8'h04;
  localparam logic [7:0] OFS_CTRL       = 8'h08;
  localparam logic [7:0] OFS_DEADTIME   = 8'h0c;
  localparam logic [7:0] OFS_PERIOD     = 8'h10;
  localparam logic [7:0] OFS_COMPARE    = 8'h30;
  localparam logic [7:0] OFS_COUNT      = 8'h50;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h70;
  localparam logic [7:0] OFS_IRQ_IND    = 8'h74;
  localparam logic [7:0] OFS_CAP_CTRL   = 8'h78;
  localparam logic [7:0] OFS_RISE_LATCH = 8'h88;
  localparam logic [7:0] OFS_FALL_LATCH = 8'ha8;

  // Field positions
  localparam int CTRL_RUN_POS  = 0;
  localparam int CTRL_AUTO_POS = 8;
  localparam int CTRL_DZ_POS   = 16;
  localparam int CLKSEL_STRIDE = 4;
  localparam int PRE_STRIDE    = 8;
  localparam int CAP_HALF      = 16;
  localparam int CAP_RIE_POS   = 1;
  localparam int CAP_FIE_POS   = 2;
  localparam int CAP_EN_POS    = 3;
  localparam int CAP_RFLAG_POS = 6;
  localparam int CAP_FFLAG_POS = 7;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0;
  localparam logic [15:0] RST_HALF  = 16'h0;
  localparam logic [7:0]  RST_FLAGS = 8'h0;

  // Clock divider selections
  localparam logic [2:0] DIV_1  = 3'h0;
  localparam logic [2:0] DIV_2  = 3'h1;
  localparam logic [2:0] DIV_4  = 3'h2;
  localparam logic [2:0] DIV_8  = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h4;

  typedef struct packed {
    logic        run;
    logic        auto_rl;
    logic [15:0] period;
    logic [15:0] compare;
  } pwc_tmr_cfg_s;

  typedef enum {PWC_IDLE, PWC_RUN, PWC_HALT} pwc_tmr_e;
endpackage

// ---- core/pwc_timer.sv ----
// One PWM timer: double-buffered 16-bit down-counter and comparator
`timescale 1ns/1ps
module pwc_timer (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 tick_i,
  input  wire pwc_pkg::pwc_tmr_cfg_s cfg_i,
  input  wire logic                 cap_reload_i,
  output logic [15:0]               count_o,
  output logic                      wave_o,
  output logic                      zero_o
);
  import pwc_pkg::*;

  pwc_tmr_e    state;
  logic [15:0] cmp_act;
  logic        start;
  logic        at_zero;

  assign start   = (state == PWC_IDLE) && cfg_i.run;
  assign at_zero = (state == PWC_RUN) && tick_i && (count_o == RST_HALF);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= PWC_IDLE;
    end else begin
      case (state)
        PWC_IDLE: if (cfg_i.run) state <= PWC_RUN;
        PWC_RUN: begin
          if (!cfg_i.run) state <= PWC_IDLE;
          else if (at_zero && !cfg_i.auto_rl) state <= PWC_HALT; // [RULE_11]
        end
        PWC_HALT: if (!cfg_i.run) state <= PWC_IDLE;
        default: state <= PWC_IDLE;
      endcase
    end
  end

  // Buffers move to the active counter and comparator at start and at an auto-reload zero; a capture reload, even on a zero, moves the period only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= RST_HALF;
      cmp_act <= RST_HALF;
    end else if (start) begin
      count_o <= cfg_i.period;
      cmp_act <= cfg_i.compare;
    end else if (state == PWC_RUN && cap_reload_i) begin
      count_o <= cfg_i.period; // [RULE_18]
    end else if (at_zero) begin
      if (cfg_i.auto_rl) begin
        count_o <= cfg_i.period; // [RULE_10] [RULE_09]
        cmp_act <= cfg_i.compare; // [RULE_09]
      end
    end else if (state == PWC_RUN && tick_i) begin
      count_o <= count_o - 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || state == PWC_IDLE) begin
      wave_o <= 1'b0;
    end else if (start || (at_zero && cfg_i.auto_rl)) begin
      wave_o <= 1'b0; // [RULE_21]
    end else if (state == PWC_RUN && tick_i && count_o != RST_HALF
                 && (count_o - 16'h1) == cmp_act) begin
      wave_o <= 1'b1; // [RULE_12]
    end
  end

  // One pulse per zero; a halted one-shot timer gives no more
  always_ff @(posedge clk_i) begin
    if (srst_i) zero_o <= 1'b0;
    else zero_o <= at_zero && cfg_i.run; // [RULE_04] [RULE_11]
  end
endmodule

// ---- core/pwc_top.sv ----
// PWM group with capture: registers, prescalers, dead zone and capture
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) Eight channels from four generators, alone or as four pairs.
// (RULE_02) Each generator has an 8-bit prescaler, then a 1/2/4/8/16 divider.
// (RULE_03) Each timer: own clock select, 16-bit down-counter, 16-bit compare.
// (RULE_04) A channel flag is set whenever its down-counter reaches zero.
// (RULE_05) A flag reaches the interrupt line only if its enable is set.
// (RULE_06) Each timer runs one-shot or auto-reload.
// (RULE_07) Pair 0 enable makes channels 0,1 complementary from timer 0.
// (RULE_08) Pairs 2-3, 4-5, 6-7 follow timers 2, 4, 6 and their dead zones.
// (RULE_09) Buffered period and compare load when the counter hits zero; the code loads them at a zero only in auto-reload mode.
// (RULE_10) Auto-reload: at zero reload from the period and keep counting.
// (RULE_11) One-shot: at zero halt and raise exactly one interrupt.
// (RULE_12) Output goes high when counter equals compare.
// (RULE_13) Capture enabled: pin stops driving and becomes an input.
// (RULE_14) Software sets up timer n before enabling capture on channel n.
// (RULE_15) Rising edge latches counter to rise latch, falling to fall latch.
// (RULE_16) Rise/fall irq enables: bits 1,2 and 17,18 of low capture reg.
// (RULE_17) Channels 2,3 of a group have the same enables in the high reg.
// (RULE_18) A capture interrupt reloads counter n at once.
// (RULE_19) Software reads indicator, then latch, then writes one to clear.
// (RULE_20) The input must not toggle again before service finishes.
// (RULE_21) Each reload drives the output low until the compare match; a capture reload leaves the output unchanged.
module pwc_top (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  cap_in_i,
  output logic [7:0]       pwm_out_ch_o,
  output logic [7:0]       pwm_oe_n_o,
  output logic             irq_o
);
  import pwc_pkg::*;

  logic [31:0]  pwm_prescale_reg;
  logic [31:0]  clk_select_reg;
  logic [31:0]  pwm_control_reg;
  logic [31:0]  dead_time_reg;
  logic [15:0]  period_reload_reg [NCH];
  logic [15:0]  compare_buf [NCH];
  logic [15:0]  count [NCH];
  logic [15:0]  rising_latch_reg [NCH];
  logic [15:0]  falling_latch_reg [NCH];
  logic [15:0]  cap_half [NCH];
  logic [7:0]   irq_enable;
  logic [7:0]   pwm_irq_indicator;
  logic [7:0]   cap_en;
  logic [7:0]   rise_ie;
  logic [7:0]   fall_ie;
  logic [7:0]   rise_flag;
  logic [7:0]   fall_flag;
  logic [7:0]   cap_q;
  logic [7:0]   rise_ev;
  logic [7:0]   fall_ev;
  logic [7:0]   cap_reload;
  logic [7:0]   wave;
  logic [7:0]   zero;
  logic [7:0]   tmr_tick;
  logic [7:0]   next_out;
  logic [3:0]   pre_tick;
  logic [3:0]   dz_done;
  logic [3:0]   dz_en;
  logic [7:0]   pre_cnt [NGEN];
  logic [3:0]   div_cnt [NCH];
  logic [7:0]   dz_cnt [NPAIR];
  logic [3:0]   dz_src_q;
  logic         req;
  logic         ack;
  logic         wr;
  logic [31:0]  next_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic [3:0] div_mask(input logic [2:0] sel);
    case (sel)
      DIV_2:   return 4'h1;
      DIV_4:   return 4'h3;
      DIV_8:   return 4'h7;
      DIV_16:  return 4'hf;
      default: return 4'h0;
    endcase
  endfunction

  // Avalon slave: one wait state, write applied and data ready at ack
  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack;
  assign wr                = avs_write_i && ack;

  always_ff @(posedge clk_i) begin
    if (srst_i) ack <= 1'b0;
    else ack <= req && !ack;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) avs_readdata_o <= RST_WORD;
    else if (avs_read_i && !ack) avs_readdata_o <= next_rdata;
  end

  always_comb begin
    next_rdata = RST_WORD;
    case ({avs_address_i[7:2], 2'b00})
      OFS_PRESCALE: next_rdata = pwm_prescale_reg;
      OFS_CLKSEL:   next_rdata = clk_select_reg;
      OFS_CTRL:     next_rdata = pwm_control_reg;
      OFS_DEADTIME: next_rdata = dead_time_reg;
      OFS_IRQ_EN:   next_rdata = {24'h0, irq_enable};
      OFS_IRQ_IND:  next_rdata = {24'h0, pwm_irq_indicator};
      default:      next_rdata = RST_WORD;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (avs_address_i[7:2] == 6'((OFS_PERIOD >> 2) + i))
        next_rdata = {16'h0, period_reload_reg[i]};
      if (avs_address_i[7:2] == 6'((OFS_COMPARE >> 2) + i))
        next_rdata = {16'h0, compare_buf[i]};
      if (avs_address_i[7:2] == 6'((OFS_COUNT >> 2) + i))
        next_rdata = {16'h0, count[i]};
      if (avs_address_i[7:2] == 6'((OFS_RISE_LATCH >> 2) + i))
        next_rdata = {16'h0, rising_latch_reg[i]};
      if (avs_address_i[7:2] == 6'((OFS_FALL_LATCH >> 2) + i))
        next_rdata = {16'h0, falling_latch_reg[i]};
    end
    for (int k = 0; k < NPAIR; k++) begin
      if (avs_address_i[7:2] == 6'((OFS_CAP_CTRL >> 2) + k))
        next_rdata = {cap_half[2*k+1], cap_half[2*k]}; // [RULE_16] [RULE_17]
    end
  end

  // Configuration words
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwm_prescale_reg <= RST_WORD;
      clk_select_reg   <= RST_WORD;
      pwm_control_reg  <= RST_WORD;
      dead_time_reg    <= RST_WORD;
      irq_enable       <= RST_FLAGS;
    end else if (wr) begin
      case ({avs_address_i[7:2], 2'b00})
        OFS_PRESCALE:
          pwm_prescale_reg <= merge(pwm_prescale_reg, avs_writedata_i,
                                    avs_byteenable_i);
        OFS_CLKSEL:
          clk_select_reg <= merge(clk_select_reg, avs_writedata_i,
                                  avs_byteenable_i);
        OFS_CTRL:
          pwm_control_reg <= merge(pwm_control_reg, avs_writedata_i,
                                   avs_byteenable_i);
        OFS_DEADTIME:
          dead_time_reg <= merge(dead_time_reg, avs_writedata_i,
                                 avs_byteenable_i);
        OFS_IRQ_EN:
          irq_enable <= 8'(merge({24'h0, irq_enable}, avs_writedata_i,
                                 avs_byteenable_i)); // [RULE_05]
        default: ;
      endcase
    end
  end

  // Interrupt line: gated period flags plus gated capture flags
  always_ff @(posedge clk_i) begin
    if (srst_i) irq_o <= 1'b0;
    else irq_o <= |(pwm_irq_indicator & irq_enable)
                  | |(rise_flag & rise_ie)
                  | |(fall_flag & fall_ie); // [RULE_05] [RULE_16]
  end

  // Prescaler per generator, divide by value plus one
  for (genvar g = 0; g < NGEN; g++) begin : g_gen
    logic [7:0] psc;
    assign psc         = pwm_prescale_reg[g*PRE_STRIDE +: 8];
    assign pre_tick[g] = (pre_cnt[g] == psc);

    always_ff @(posedge clk_i) begin
      if (srst_i || pre_tick[g]) pre_cnt[g] <= RST_FLAGS;
      else pre_cnt[g] <= pre_cnt[g] + 8'h1; // [RULE_02]
    end
  end

  // Per-channel divider, timer, capture and register slices
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam logic [7:0] CAP_OFS = 8'(OFS_CAP_CTRL + 4 * (n / 2));
    localparam int         H       = CAP_HALF * (n % 2);
    localparam logic [7:0] PER_OFS = 8'(OFS_PERIOD + 4 * n);
    localparam logic [7:0] CMP_OFS = 8'(OFS_COMPARE + 4 * n);
    pwc_tmr_cfg_s cfg;
    logic         cap_wr;
    logic [2:0]   sel;

    assign sel         = clk_select_reg[n*CLKSEL_STRIDE +: 3];
    assign tmr_tick[n] = pre_tick[n/2] // [RULE_02]
                         && ((div_cnt[n] & div_mask(sel)) == 4'h0);
    assign cfg.run     = pwm_control_reg[CTRL_RUN_POS + n];
    assign cfg.auto_rl = pwm_control_reg[CTRL_AUTO_POS + n]; // [RULE_06]
    assign cfg.period  = period_reload_reg[n];
    assign cfg.compare = compare_buf[n];
    assign cap_wr      = wr && ({avs_address_i[7:2], 2'b00} == CAP_OFS)
                         && avs_byteenable_i[H/8];
    assign cap_half[n] = {8'h0, fall_flag[n], rise_flag[n], 2'b00,
                          cap_en[n], fall_ie[n], rise_ie[n], 1'b0};

    always_ff @(posedge clk_i) begin
      if (srst_i) div_cnt[n] <= 4'h0;
      else if (pre_tick[n/2]) div_cnt[n] <= div_cnt[n] + 4'h1;
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        period_reload_reg[n] <= RST_HALF;
        compare_buf[n]       <= RST_HALF;
      end else if (wr) begin
        if ({avs_address_i[7:2], 2'b00} == PER_OFS)
          period_reload_reg[n] <= 16'(merge({16'h0, period_reload_reg[n]},
                                           avs_writedata_i,
                                           avs_byteenable_i)); // [RULE_09]
        if ({avs_address_i[7:2], 2'b00} == CMP_OFS)
          compare_buf[n] <= 16'(merge({16'h0, compare_buf[n]},
                                     avs_writedata_i,
                                     avs_byteenable_i)); // [RULE_09]
      end
    end

    pwc_timer u_timer (
      .clk_i        (clk_i),
      .srst_i       (srst_i),
      .tick_i       (tmr_tick[n]),
      .cfg_i        (cfg),
      .cap_reload_i (cap_reload[n]),
      .count_o      (count[n]),
      .wave_o       (wave[n]),
      .zero_o       (zero[n])
    ); // [RULE_03]

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        pwm_irq_indicator[n] <= 1'b0;
      end else begin
        pwm_irq_indicator[n] <= zero[n] || (pwm_irq_indicator[n]
          && !(wr && {avs_address_i[7:2], 2'b00} == OFS_IRQ_IND
               && avs_byteenable_i[0] && avs_writedata_i[n])); // [RULE_04]
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        cap_en[n]  <= 1'b0;
        rise_ie[n] <= 1'b0;
        fall_ie[n] <= 1'b0;
      end else if (cap_wr) begin
        cap_en[n]  <= avs_writedata_i[H + CAP_EN_POS];
        rise_ie[n] <= avs_writedata_i[H + CAP_RIE_POS]; // [RULE_16]
        fall_ie[n] <= avs_writedata_i[H + CAP_FIE_POS]; // [RULE_17]
      end
    end

    // Pin inputs are synchronous, so a single stage feeds edge detection
    assign rise_ev[n]    = cap_en[n] && cap_in_i[n] && !cap_q[n];
    assign fall_ev[n]    = cap_en[n] && !cap_in_i[n] && cap_q[n];
    assign cap_reload[n] = (rise_ev[n] && rise_ie[n])
                           || (fall_ev[n] && fall_ie[n]); // [RULE_18]

    always_ff @(posedge clk_i) begin
      if (srst_i) cap_q[n] <= 1'b0;
      else cap_q[n] <= cap_in_i[n];
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rising_latch_reg[n]  <= RST_HALF;
        falling_latch_reg[n] <= RST_HALF;
      end else begin
        if (rise_ev[n]) rising_latch_reg[n] <= count[n]; // [RULE_15]
        if (fall_ev[n]) falling_latch_reg[n] <= count[n]; // [RULE_15]
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rise_flag[n] <= 1'b0;
        fall_flag[n] <= 1'b0;
      end else begin
        rise_flag[n] <= rise_ev[n] || (rise_flag[n]
          && !(cap_wr && avs_writedata_i[H + CAP_RFLAG_POS]));
        fall_flag[n] <= fall_ev[n] || (fall_flag[n]
          && !(cap_wr && avs_writedata_i[H + CAP_FFLAG_POS]));
      end
    end
  end

  // Dead zone per pair, driven by the even timer of the pair
  for (genvar p = 0; p < NPAIR; p++) begin : g_pair
    logic [7:0] dtime;
    assign dtime      = dead_time_reg[p*8 +: 8];
    assign dz_en[p]   = pwm_control_reg[CTRL_DZ_POS + p]; // [RULE_07]
    // Quiet only when no source edge is pending or the dead time is zero, so no glitch leaks out
    assign dz_done[p] = (dz_cnt[p] == RST_FLAGS)
                        && (wave[2*p] == dz_src_q[p] || dtime == RST_FLAGS);

    // Each edge of the source restarts the dead time in prescaled ticks
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        dz_cnt[p]   <= RST_FLAGS;
        dz_src_q[p] <= 1'b0;
      end else begin
        dz_src_q[p] <= wave[2*p];
        // The cycle that sees the edge is already blanked, so it counts
        if (wave[2*p] != dz_src_q[p]) // [RULE_08]
          dz_cnt[p] <= dtime - 8'(pre_tick[p] && dtime != RST_FLAGS);
        else if (!dz_done[p] && pre_tick[p]) dz_cnt[p] <= dz_cnt[p] - 8'h1;
      end
    end

    always_comb begin
      if (dz_en[p]) begin
        next_out[2*p]   = wave[2*p] && dz_done[p]; // [RULE_07] [RULE_08]
        next_out[2*p+1] = !wave[2*p] && dz_done[p]
                          && pwm_control_reg[CTRL_RUN_POS + 2*p];
      end else begin
        next_out[2*p]   = wave[2*p]; // [RULE_01]
        next_out[2*p+1] = wave[2*p+1];
      end
    end
  end

  // A capturing channel releases its pin and holds its output low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwm_out_ch_o <= RST_FLAGS;
      pwm_oe_n_o   <= 8'hff;
    end else begin
      pwm_out_ch_o <= next_out & ~cap_en; // [RULE_13]
      pwm_oe_n_o   <= cap_en; // [RULE_13]
    end
  end
endmodule

// ---- testbench/pwc_monitor.sv ----
// Port-level checks for the PWM group with capture
`timescale 1ns/1ps
module pwc_monitor (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [7:0]  pwm_out_ch_o,
  input  wire logic [7:0]  pwm_oe_n_o,
  input  wire logic        irq_o
);
  logic req;
  logic ack;
  assign req = avs_read_i | avs_write_i;
  assign ack = avs_write_i & ~avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wait_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  no_req_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  reack_a: assert property (req && !avs_waitrequest_o |=>
    !req || avs_waitrequest_o)
    else $error("held request acked twice");
  rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[7:2] == 6'h3f |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  cap_quiet_a: assert property (
    (pwm_out_ch_o & pwm_oe_n_o) == 8'h00)
    else $error("released pin still driven high");
  oe_by_write_a: assert property ($changed(pwm_oe_n_o) |->
    $past(ack) || $past(ack, 2) || $past(srst_i, 2))
    else $error("pin direction changed without write");
  irq_clear_a: assert property ($fell(irq_o) |->
    $past(ack) || $past(ack, 2) || $past(ack, 3))
    else $error("interrupt dropped without write");
  cover property ($rose(irq_o));
  cover property (ack && avs_address_i == 8'h78);
  cover property ($fell(pwm_oe_n_o[0]));
endmodule

bind pwc_top pwc_monitor i_pwc_monitor (
  .clk_i             (clk_i),
  .srst_i            (srst_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .pwm_out_ch_o      (pwm_out_ch_o),
  .pwm_oe_n_o        (pwm_oe_n_o),
  .irq_o             (irq_o)
);

// ---- testbench/pwc_pin_model.sv ----
// Signal source on the capture pins and resolution of the pin level
`timescale 1ns/1ps
module pwc_pin_model #(
  parameter int GAP = 8
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  input  wire logic [7:0] pwm_out_ch_i,
  input  wire logic [7:0] pwm_oe_n_i,
  output logic [7:0]      pin_o
);
  logic [7:0]  src = 8'h00;
  int unsigned quiet [8] = '{default: GAP};
  // A request inside the quiet gap waits, so service always has time
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 8; k++) begin
      if (want_i[k] != src[k] && quiet[k] >= GAP) begin
        src[k]   <= want_i[k];
        quiet[k] <= 0;
      end else if (quiet[k] < GAP) begin
        quiet[k] <= quiet[k] + 1;
      end
    end
  end
  assign pin_o = (pwm_oe_n_i & src) | (~pwm_oe_n_i & pwm_out_ch_i);
endmodule

// ---- testbench/pwc_top_tb.sv ----
// Register-level tests of the PWM group with capture
`timescale 1ns/1ps
module pwc_top_tb;
  import pwc_pkg::*;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  pin;
  logic [7:0]  want = 8'h00;
  logic [7:0]  pwm_out_ch_o;
  logic [7:0]  pwm_oe_n_o;
  logic        irq_o;
  int          bad_count = 0;
  int          comparisons = 0;

  pwc_top i_pwc_top (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cap_in_i(pin), .pwm_out_ch_o(pwm_out_ch_o), .pwm_oe_n_o(pwm_oe_n_o),
    .irq_o(irq_o));
  pwc_pin_model i_pwc_pin_model (
    .clk_i(clk_i), .want_i(want), .pwm_out_ch_i(pwm_out_ch_o),
    .pwm_oe_n_i(pwm_oe_n_o), .pin_o(pin));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input logic [31:0] got, lo, hi, input string what);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // First pass finds a rising edge, second times one full period;
  // two idle edges first skip a rise launched under old settings
  task automatic meas(input int ch, output int hi, output int per);
    logic prev;
    repeat (2) @(posedge clk_i);
    repeat (2) begin
      hi = 0;
      per = 0;
      do begin
        prev = pwm_out_ch_o[ch];
        @(posedge clk_i);
        per++;
        if (pwm_out_ch_o[ch] === 1'b1) hi++;
      end while (!(prev === 1'b0 && pwm_out_ch_o[ch] === 1'b1));
    end
  endtask

  task automatic cap_edge(input int ch, input logic lvl, input logic rl);
    logic [31:0] lat, c;
    want[ch] <= lvl;
    repeat (4) @(posedge clk_i);
    rd((lvl ? OFS_RISE_LATCH : OFS_FALL_LATCH) + 8'(4 * ch), lat);
    rd(OFS_COUNT + 8'(4 * ch), c);
    rng(lat, 0, 1000, "latch");
    if (rl) rng(c, 985, 1000, "reload");
    else rng(c, 0, lat - 1, "no reload");
    repeat (20) @(posedge clk_i);
  endtask

  task automatic cap_test(input int ch, input logic rie, input logic fie);
    logic [7:0]  a;
    logic [31:0] en, m, v;
    a  = OFS_CAP_CTRL + 8'(4 * (ch / 2));
    en = 32'({1'b1, fie, rie, 1'b0}) << (16 * (ch % 2));
    m  = 32'hc0 << (16 * (ch % 2));
    wr(a, en);
    @(posedge clk_i);
    chk(pwm_oe_n_o[ch], 1'b1, "pin released");
    chk(pwm_out_ch_o[ch], 1'b0, "pin quiet");
    cap_edge(ch, 1'b1, rie);
    cap_edge(ch, 1'b0, fie);
    rd(a, v);
    chk(v & m, m, "capture flags");
    wr(a, en | m);
    rd(a, v);
    chk(v & m, 32'h0, "flags cleared");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin : main
    logic [31:0] v;
    int          hi, per;
    repeat (10) @(posedge clk_i);
    chk(pwm_oe_n_o, 8'hff, "oe reset");
    chk({pwm_out_ch_o, 7'h0, irq_o}, 16'h0, "out reset");
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_CTRL, v);
    chk(v, RST_WORD, "ctrl reset");
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, v);
    chk(v, 32'h0, "unmapped");
    $display("test reset done");

    wr(OFS_PERIOD, 32'd9);
    wr(OFS_COMPARE, 32'd4);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_CTRL, 32'h0101);
    meas(0, hi, per);
    chk(per, 10, "period");
    chk(hi, 5, "high width");
    rd(OFS_IRQ_IND, v);
    chk(v[0], 1'b1, "zero flag");
    chk(irq_o, 1'b1, "irq enabled");
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_IRQ_IND, 32'h1);
    repeat (15) @(posedge clk_i);
    rd(OFS_IRQ_IND, v);
    chk(v[0], 1'b1, "flag again");
    chk(irq_o, 1'b0, "irq masked");
    wr(OFS_PERIOD, 32'd19);
    rd(OFS_COUNT, v);
    rng(v, 0, 9, "buffered period");
    // Let the old period finish so the measured one is wholly new
    repeat (10) @(posedge clk_i);
    meas(0, hi, per);
    chk(per, 20, "new period");
    $display("test auto reload done");

    wr(OFS_PERIOD + 8'h4, 32'd5);
    wr(OFS_COMPARE + 8'h4, 32'd2);
    wr(OFS_IRQ_IND, 32'hff);
    wr(OFS_CTRL, 32'h0103);
    repeat (30) @(posedge clk_i);
    rd(OFS_IRQ_IND, v);
    chk(v[1], 1'b1, "one-shot flag");
    wr(OFS_IRQ_IND, 32'h2);
    repeat (30) @(posedge clk_i);
    rd(OFS_IRQ_IND, v);
    chk(v[1], 1'b0, "single flag");
    rd(OFS_COUNT + 8'h4, v);
    chk(v, 32'h0, "halted");
    $display("test one-shot done");

    wr(OFS_PERIOD + 8'h8, 32'd3);
    wr(OFS_COMPARE + 8'h8, 32'd1);
    wr(OFS_CTRL, 32'h0404);
    for (int d = 0; d < 5; d++) begin
      wr(OFS_CLKSEL, 32'(d) << 8);
      meas(2, hi, per);
      chk(per, 4 << d, "divided period");
      chk(hi, 2 << d, "divided high");
    end
    wr(OFS_CLKSEL, 32'h100);
    wr(OFS_PRESCALE, 32'h200);
    meas(2, hi, per);
    chk(per, 24, "prescaled period");
    $display("test divider done");

    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_CLKSEL, 32'h0);
    wr(OFS_DEADTIME, 32'h02020202);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_PERIOD + 8'(8 * p), 32'd9);
      wr(OFS_COMPARE + 8'(8 * p), 32'd4);
    end
    wr(OFS_CTRL, 32'h000f5555);
    for (int k = 0; k < 8; k++) begin
      meas(k, hi, per);
      chk(per, 10, "pair period");
      chk(hi, 3, "pair dead time");
    end
    $display("test pairs done");

    wr(OFS_PERIOD + 8'h4, 32'd1000);
    wr(OFS_PERIOD + 8'h8, 32'd1000);
    wr(OFS_CTRL, 32'h0606);
    repeat (10) @(posedge clk_i);
    cap_test(1, 1'b1, 1'b0);
    cap_test(2, 1'b0, 1'b1);
    $display("test capture done");
    report_and_stop();
  end
endmodule
